// File: rtl/lipc_pkg.sv
// Purpose: Shared constants for the level interrupt priority controller
// Assumes: 8-bit register file addressing, eight request levels
// Notes: Register offsets are byte addresses in the control register set
package lipc_pkg;
   localparam int LEVELS = 8;
   localparam int LVL_W = 3;
   localparam int SLOTS_DEF = 4;

   localparam logic [7:0] ADDR_PENDING = 8'hdc;
   localparam logic [7:0] ADDR_MASK = 8'hdd;
   localparam logic [7:0] ADDR_SYSMODE = 8'hde;
   localparam logic [7:0] ADDR_PRIO = 8'hff;

   localparam logic [7:0] PENDING_RST = 8'h00;
   localparam logic [7:0] SYSMODE_RST = 8'h00;
   localparam logic [7:0] RDATA_NONE = 8'h00;
   localparam int GE_BIT = 0;

   // Priority configuration field positions
   localparam int PRIO_A_BIT = 0;
   localparam int PRIO_B_BIT = 2;
   localparam int PRIO_BSUB_BIT = 3;
   localparam int PRIO_C_BIT = 5;
   localparam int PRIO_CSUB_BIT = 6;
   localparam int PRIO_G2_BIT = 7;
   localparam int PRIO_G1_BIT = 4;
   localparam int PRIO_G0_BIT = 1;

   // Group order codes on bits {7,4,1}, leftmost group most urgent
   localparam logic [2:0] GRP_BCA = 3'h1;
   localparam logic [2:0] GRP_ABC = 3'h2;
   localparam logic [2:0] GRP_BAC = 3'h3;
   localparam logic [2:0] GRP_CAB = 3'h4;
   localparam logic [2:0] GRP_CBA = 3'h5;
   localparam logic [2:0] GRP_ACB = 3'h6;

   localparam logic [2:0] LV0 = 3'h0;
   localparam logic [2:0] LV1 = 3'h1;
   localparam logic [2:0] LV2 = 3'h2;
   localparam logic [2:0] LV3 = 3'h3;
   localparam logic [2:0] LV4 = 3'h4;
   localparam logic [2:0] LV5 = 3'h5;
   localparam logic [2:0] LV6 = 3'h6;
   localparam logic [2:0] LV7 = 3'h7;
endpackage

// File: rtl/lipc_top.sv
// Purpose: Global enable, level mask, programmable level priority and pending flags
// Assumes: CPU core and sources run on i_mclk; CPU pulses are one cycle wide
// Notes: Mask and priority registers have no reset value by design
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01: Within-level index zero is most urgent
// R02: Lowest vector slot wins within a level
// R03: Enable instruction sets, disable clears global bit
// R04: Init software must run the enable instruction
// R05: Reset clears the global enable bit
// R06: Global enable bit also directly writable
// R07: Mask bit n permits level n when one
// R08: Mask contents undefined after reset
// R09: Software disables globally before changing mask
// R10: Priority register undefined after reset
// R11: Levels grouped 0-1, 2-4, 5-7
// R12: Bits 7,4,1 choose order of groups
// R13: Bit 5 orders group three, bit 6 subgroup
// R14: Bit 0 orders level 0 versus 1
// R15: Highest ranked active level is serviced first
// R16: Service needs global enable, mask and source enable
// R17: Read-only pending flag per level
// R18: Reset clears all pending flags
// R19: Flags capture and read while globally disabled
// R20: Accept clears enable; return sets it again
// R21: Level 0 source cleared by hardware on acknowledge
// R22: Remaining group patterns fill full table
module lipc_top #(
   parameter int SLOTS = lipc_pkg::SLOTS_DEF
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [7:0] i_addr,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_ei,
   input wire logic i_di,
   input wire logic i_return_from_handler,
   input wire logic i_ack,
   input wire logic [lipc_pkg::LEVELS*SLOTS-1:0] i_src_req,
   input wire logic [lipc_pkg::LEVELS*SLOTS-1:0] i_src_en,
   output logic o_irq,
   output logic [lipc_pkg::LVL_W-1:0] o_vec_level,
   output logic [$clog2(SLOTS)-1:0] o_vec_slot,
   output logic o_lvl0_clr,
   output logic o_global_en
);
   localparam int SW = $clog2(SLOTS);

   logic [7:0] pending_q;
   logic [7:0] mask_q;
   logic [7:0] sysmode_q;
   logic [7:0] prio_q;
   logic [lipc_pkg::LEVELS-1:0] lvl_req;
   logic [lipc_pkg::LEVELS-1:0] lvl_svc;
   logic [lipc_pkg::LEVELS-1:0][SLOTS-1:0] src_ok;
   logic found_d;
   logic [2:0] win_d;
   logic [SW-1:0] slot_d;
   logic [23:0] order;
   logic take_ack;

   // Per-level request collection: pending ignores source enable, service needs it
   genvar gl;
   generate
      for (gl = 0; gl < lipc_pkg::LEVELS; gl++) begin : g_lvl
         assign src_ok[gl] = i_src_req[gl*SLOTS +: SLOTS] & i_src_en[gl*SLOTS +: SLOTS];
         assign lvl_req[gl] = |i_src_req[gl*SLOTS +: SLOTS];
         assign lvl_svc[gl] = (|src_ok[gl]) & mask_q[gl]; // R07 R16
      end
   endgenerate

   assign take_ack = i_ack & o_irq;

   // Pending flags follow level requests regardless of global enable
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         pending_q <= lipc_pkg::PENDING_RST; // R18
      end else begin
         pending_q <= lvl_req; // R17 R19
      end
   end

   // Mask and priority hold no reset; software must program them
   always_ff @(posedge i_mclk) begin
      if (i_wr && i_addr == lipc_pkg::ADDR_MASK) begin
         mask_q <= i_wdata; // R08
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_wr && i_addr == lipc_pkg::ADDR_PRIO) begin
         prio_q <= i_wdata; // R10
      end
   end

   // Acknowledge clear wins so no second request is taken before stacking
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sysmode_q <= lipc_pkg::SYSMODE_RST; // R05
      end else begin
         if (i_wr && i_addr == lipc_pkg::ADDR_SYSMODE) begin
            sysmode_q <= i_wdata; // R06
         end
         if (i_ei || i_return_from_handler) begin
            sysmode_q[lipc_pkg::GE_BIT] <= 1'b1; // R03 R20
         end
         if (i_di) begin
            sysmode_q[lipc_pkg::GE_BIT] <= 1'b0; // R03
         end
         if (take_ack) begin
            sysmode_q[lipc_pkg::GE_BIT] <= 1'b0; // R20
         end
      end
   end

   // Build the urgency order of all levels, most urgent at the top bits
   always_comb begin
      logic [5:0] la;
      logic [8:0] lb;
      logic [8:0] lc;
      logic [5:0] bsub;
      logic [5:0] csub;
      la = 6'h0;
      lb = 9'h0;
      lc = 9'h0;
      bsub = 6'h0;
      csub = 6'h0;
      if (prio_q[lipc_pkg::PRIO_A_BIT]) begin
         la = {lipc_pkg::LV1, lipc_pkg::LV0}; // R14
      end else begin
         la = {lipc_pkg::LV0, lipc_pkg::LV1}; // R14
      end
      if (prio_q[lipc_pkg::PRIO_BSUB_BIT]) begin
         bsub = {lipc_pkg::LV4, lipc_pkg::LV3};
      end else begin
         bsub = {lipc_pkg::LV3, lipc_pkg::LV4};
      end
      if (prio_q[lipc_pkg::PRIO_B_BIT]) begin
         lb = {bsub, lipc_pkg::LV2};
      end else begin
         lb = {lipc_pkg::LV2, bsub};
      end
      if (prio_q[lipc_pkg::PRIO_CSUB_BIT]) begin
         csub = {lipc_pkg::LV7, lipc_pkg::LV6}; // R13
      end else begin
         csub = {lipc_pkg::LV6, lipc_pkg::LV7}; // R13
      end
      if (prio_q[lipc_pkg::PRIO_C_BIT]) begin
         lc = {csub, lipc_pkg::LV5}; // R13
      end else begin
         lc = {lipc_pkg::LV5, csub}; // R13
      end
      // Groups are used by the ordering only, never for masking
      case ({prio_q[lipc_pkg::PRIO_G2_BIT], prio_q[lipc_pkg::PRIO_G1_BIT],
             prio_q[lipc_pkg::PRIO_G0_BIT]}) // R11 R12
         lipc_pkg::GRP_BCA: begin
            order = {lb, lc, la}; // R12
         end
         lipc_pkg::GRP_CBA: begin
            order = {lc, lb, la}; // R12
         end
         lipc_pkg::GRP_ABC: begin
            order = {la, lb, lc}; // R22
         end
         lipc_pkg::GRP_BAC: begin
            order = {lb, la, lc}; // R22
         end
         lipc_pkg::GRP_CAB: begin
            order = {lc, la, lb}; // R22
         end
         lipc_pkg::GRP_ACB: begin
            order = {la, lc, lb}; // R22
         end
         default: begin
            order = {la, lb, lc}; // R22
         end
      endcase
   end

   // Walk from least to most urgent so the most urgent active entry is kept last
   always_comb begin
      logic [2:0] lv;
      lv = 3'h0;
      found_d = 1'b0;
      win_d = 3'h0;
      slot_d = '0;
      for (int k = lipc_pkg::LEVELS - 1; k >= 0; k--) begin
         lv = order[23 - 3*k -: 3];
         if (lvl_svc[lv]) begin
            found_d = 1'b1; // R15
            win_d = lv;
         end
      end
      for (int s = SLOTS - 1; s >= 0; s--) begin
         if (src_ok[win_d][s]) begin
            slot_d = SW'(s); // R01 R02
         end
      end
   end

   // Request drops the cycle after an acknowledge; vector follows the resolver every cycle
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_irq <= 1'b0;
         o_vec_level <= '0;
         o_vec_slot <= '0;
      end else begin
         o_irq <= found_d & sysmode_q[lipc_pkg::GE_BIT] & ~take_ack; // R16
         o_vec_level <= win_d;
         o_vec_slot <= slot_d;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_lvl0_clr <= 1'b0;
      end else begin
         o_lvl0_clr <= take_ack && o_vec_level == lipc_pkg::LV0; // R21
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_global_en <= 1'b0;
      end else begin
         o_global_en <= sysmode_q[lipc_pkg::GE_BIT];
      end
   end

   // Unmapped reads return zero; pending register ignores writes
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= lipc_pkg::RDATA_NONE;
      end else if (i_rd) begin
         case (i_addr)
            lipc_pkg::ADDR_PENDING: o_rdata <= pending_q; // R17
            lipc_pkg::ADDR_MASK: o_rdata <= mask_q;
            lipc_pkg::ADDR_SYSMODE: o_rdata <= sysmode_q;
            lipc_pkg::ADDR_PRIO: o_rdata <= prio_q;
            default: o_rdata <= lipc_pkg::RDATA_NONE;
         endcase
      end
   end

   // Helper history for checks only; one cycle behind, in step with the registered vector
   logic [7:0] mask_p;
   logic [lipc_pkg::LEVELS-1:0][SLOTS-1:0] ok_p;
   logic [lipc_pkg::LEVELS-1:0] svc_p;
   logic [7:0] prio_p;
   logic [2:0] grp_p;
   always_ff @(posedge i_mclk) begin
      mask_p <= mask_q;
      ok_p <= src_ok;
      svc_p <= lvl_svc;
      prio_p <= prio_q;
      grp_p <= {prio_q[lipc_pkg::PRIO_G2_BIT], prio_q[lipc_pkg::PRIO_G1_BIT],
                prio_q[lipc_pkg::PRIO_G0_BIT]};
   end

   a_ack_clears_ge: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R20
      take_ack |=> !sysmode_q[lipc_pkg::GE_BIT] ##1 !o_irq)
      else $error("global enable not cleared by acknowledge");

   a_return_from_handler_sets_ge: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R20
      (i_return_from_handler && !i_di && !take_ack) |=> sysmode_q[lipc_pkg::GE_BIT])
      else $error("return did not set global enable");

   a_di_clears_ge: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R03
      i_di |=> !sysmode_q[lipc_pkg::GE_BIT] ##1 !o_global_en)
      else $error("disable did not clear global enable");

   a_ei_sets_ge: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R03
      (i_ei && !i_di && !take_ack) |=> ##1 o_global_en)
      else $error("enable did not reach global enable output");

   a_irq_needs_ge: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R16
      o_irq |-> $past(sysmode_q[lipc_pkg::GE_BIT]))
      else $error("request raised while globally disabled");

   a_irq_unmasked: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R07 R16
      o_irq |-> mask_p[o_vec_level] && (|ok_p[o_vec_level]))
      else $error("request raised for masked or disabled level");

   a_slot_lowest: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R02
      o_irq |-> ok_p[o_vec_level][o_vec_slot]
                && ((ok_p[o_vec_level] & ((SLOTS'(1) << o_vec_slot) - SLOTS'(1))) == '0))
      else $error("vector slot not the lowest active one");

   a_pend_follows: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R19
      ##1 pending_q == $past(lvl_req))
      else $error("pending flags do not follow requests");

   a_lvl0_clear: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R21
      (take_ack && o_vec_level == lipc_pkg::LV0) |=> o_lvl0_clr ##1 !o_lvl0_clr)
      else $error("level zero clear pulse missing");

   a_pair_order: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R14
      (o_irq && o_vec_level == lipc_pkg::LV1 && svc_p[lipc_pkg::LV0])
         |-> prio_p[lipc_pkg::PRIO_A_BIT])
      else $error("level one served ahead of level zero against priority");

   a_c_head_order: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R13
      (o_irq && o_vec_level == lipc_pkg::LV5 && (svc_p[lipc_pkg::LV6] || svc_p[lipc_pkg::LV7]))
         |-> !prio_p[lipc_pkg::PRIO_C_BIT])
      else $error("level five served ahead of its subgroup against priority");

   a_group_a_last: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R12
      (o_irq && o_vec_level <= lipc_pkg::LV1
       && (grp_p == lipc_pkg::GRP_BCA || grp_p == lipc_pkg::GRP_CBA))
         |-> svc_p[lipc_pkg::LEVELS-1:lipc_pkg::LV2] == '0)
      else $error("first group served ahead of the other groups");

   a_group_c_first: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R12
      (o_irq && o_vec_level >= lipc_pkg::LV2 && o_vec_level <= lipc_pkg::LV4
       && grp_p == lipc_pkg::GRP_CBA) |-> svc_p[lipc_pkg::LV7:lipc_pkg::LV5] == '0)
      else $error("second group served ahead of third group");

   a_group_b_first: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R12
      (o_irq && o_vec_level >= lipc_pkg::LV5 && grp_p == lipc_pkg::GRP_BCA)
         |-> svc_p[lipc_pkg::LV4:lipc_pkg::LV2] == '0)
      else $error("third group served ahead of second group");

   a_idle_no_irq: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R15
      !found_d |=> !o_irq)
      else $error("request raised with no serviceable level");

   a_pend_read: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R17
      (i_rd && i_addr == lipc_pkg::ADDR_PENDING) |=> o_rdata == $past(pending_q))
      else $error("pending read returned wrong flags");

   a_sysmode_write: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R06
      (i_wr && i_addr == lipc_pkg::ADDR_SYSMODE && !i_ei && !i_di && !i_return_from_handler && !take_ack)
         |=> sysmode_q == $past(i_wdata))
      else $error("direct system mode write lost");

   a_mask_write: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R07
      (i_wr && i_addr == lipc_pkg::ADDR_MASK) |=> mask_q == $past(i_wdata))
      else $error("mask write lost");

   a_clr_cause: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R21
      o_lvl0_clr |-> $past(take_ack) && $past(o_vec_level) == lipc_pkg::LV0)
      else $error("level zero clear without its acknowledge");

endmodule
`default_nettype wire

// File: test/lipc_src_model.sv
// Purpose: Peripheral source model feeding per-source requests and enables
// Assumes: Bench loads new request and enable sets with a one-cycle pulse
// Notes: Level 0 sources drop on the hardware clear pulse, others wait for a reload
`timescale 1ns/1ps
`default_nettype none
module lipc_src_model #(
   parameter int SLOTS = 4,
   parameter int W = 32
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_load,
   input wire logic [W-1:0] i_req,
   input wire logic [W-1:0] i_en,
   input wire logic i_clr0,
   output var logic [W-1:0] o_src_req,
   output var logic [W-1:0] o_src_en
);
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_src_req <= '0;
         o_src_en <= '0;
      end else if (i_load) begin
         o_src_req <= i_req;
         o_src_en <= i_en;
      end else if (i_clr0) begin
         o_src_req[SLOTS-1:0] <= '0;
      end
   end
endmodule
`default_nettype wire

// File: test/level_interrupt_priority_control_test.sv
// Purpose: Self-checking bench for the level interrupt priority controller
// Assumes: SLOTS of 4, CPU pulses one cycle wide
// Notes: Expected winners come from a ranked-list model of the resolver
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module level_interrupt_priority_control_test;
   localparam int S = 4;
   localparam int W = 8 * S;
   localparam int GORD[8][3] = '{'{0, 1, 2}, '{1, 2, 0}, '{0, 1, 2}, '{1, 0, 2},
      '{2, 0, 1}, '{2, 1, 0}, '{0, 2, 1}, '{0, 1, 2}};
   logic i_mclk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_ei = 0, i_di = 0, i_return_from_handler = 0;
   logic i_ack = 0, ld = 0;
   logic [7:0] i_addr = 0, i_wdata = 0, o_rdata, mask, prio, pend;
   logic [W-1:0] src_req, src_en, lreq = 0, len = 0;
   logic o_irq, o_lvl0_clr, o_global_en;
   logic [2:0] o_vec_level;
   logic [1:0] o_vec_slot;
   int n_mismatch = 0, cmp_count = 0, seed = 69, lv, sl;
   always #10 i_mclk = ~i_mclk;
   lipc_top #(.SLOTS(S)) u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
      .i_wr(i_wr), .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata), .i_ei(i_ei),
      .i_di(i_di), .i_return_from_handler(i_return_from_handler), .i_ack(i_ack), .i_src_req(src_req), .i_src_en(src_en),
      .o_irq(o_irq), .o_vec_level(o_vec_level), .o_vec_slot(o_vec_slot),
      .o_lvl0_clr(o_lvl0_clr), .o_global_en(o_global_en));
   lipc_src_model #(.SLOTS(S), .W(W)) u_src (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_load(ld),
      .i_req(lreq), .i_en(len), .i_clr0(o_lvl0_clr), .o_src_req(src_req), .o_src_en(src_en));
   // Ranked list of levels built from the priority byte; first group repeats a level as filler
   function automatic int win(input logic [7:0] el, input logic [7:0] p);
      int g[3][3];
      int c;
      int f;
      int h;
      if (p[0]) g[0] = '{1, 0, 0};
      else g[0] = '{0, 1, 0};
      f = p[3] ? 4 : 3;
      if (p[2]) g[1] = '{f, 7 - f, 2};
      else g[1] = '{2, f, 7 - f};
      h = p[6] ? 7 : 6;
      if (p[5]) g[2] = '{h, 13 - h, 5};
      else g[2] = '{5, h, 13 - h};
      c = int'({p[7], p[4], p[1]});
      for (int i = 0; i < 3; i++)
         for (int j = 0; j < 3; j++)
            if (el[g[GORD[c][i]][j]]) return g[GORD[c][i]][j];
      return -1;
   endfunction
   task automatic complete_run;
      if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1;
      @(posedge i_mclk);
      i_wr <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1;
      @(posedge i_mclk);
      i_rd <= 0;
      #1 `CHK("rdata", e, o_rdata)
   endtask
   // Bits are ei, di, return_from_handler, ack
   task automatic cpu(input logic [3:0] k);
      @(posedge i_mclk);
      {i_ei, i_di, i_return_from_handler, i_ack} <= k;
      @(posedge i_mclk);
      {i_ei, i_di, i_return_from_handler, i_ack} <= 4'h0;
   endtask
   initial begin
      repeat (20000) @(posedge i_mclk);
      n_mismatch++;
      complete_run;
   end
   initial begin
      repeat (20) @(posedge i_mclk);
      i_nrst <= 1;
      rd(lipc_pkg::ADDR_SYSMODE, lipc_pkg::SYSMODE_RST);
      rd(lipc_pkg::ADDR_PENDING, lipc_pkg::PENDING_RST);
      rd(8'h10, lipc_pkg::RDATA_NONE);
      wr(lipc_pkg::ADDR_SYSMODE, 8'h01);
      rd(lipc_pkg::ADDR_SYSMODE, 8'h01);
      `CHK("global_en", 1'b1, o_global_en)
      cpu(4'h4);
      rd(lipc_pkg::ADDR_SYSMODE, 8'h00);
      for (int n = 0; n < 24; n++) begin
         mask = 8'($random(seed));
         prio = 8'($random(seed));
         if (n < 8) {prio[7], prio[4], prio[1]} = n[2:0];
         wr(lipc_pkg::ADDR_MASK, mask);
         wr(lipc_pkg::ADDR_PRIO, prio);
         rd(lipc_pkg::ADDR_MASK, mask);
         rd(lipc_pkg::ADDR_PRIO, prio);
         @(posedge i_mclk);
         ld <= 1;
         lreq <= $random(seed) & $random(seed);
         len <= $random(seed);
         @(posedge i_mclk);
         ld <= 0;
         wr(lipc_pkg::ADDR_PENDING, 8'hff);
         pend = 0;
         for (int l = 0; l < 8; l++) pend[l] = |src_req[l*S +: S];
         rd(lipc_pkg::ADDR_PENDING, pend);
         `CHK("irq_off", 1'b0, o_irq)
         cpu(4'h8);
         repeat (2) @(posedge i_mclk);
         #1 pend = 0;
         for (int l = 0; l < 8; l++) pend[l] = mask[l] & |(src_req[l*S +: S] & src_en[l*S +: S]);
         lv = win(pend, prio);
         `CHK("irq", lv >= 0, o_irq)
         if (lv >= 0) begin
            sl = 0;
            while (!(src_req[lv*S+sl] & src_en[lv*S+sl])) sl++;
            `CHK("level", 3'(lv), o_vec_level)
            `CHK("slot", 2'(sl), o_vec_slot)
            cpu(4'h1);
            #1 `CHK("irq_ack", 1'b0, o_irq)
            `CHK("lvl0_clr", lv == 0, o_lvl0_clr)
            @(posedge i_mclk);
            #1 `CHK("global_en", 1'b0, o_global_en)
            cpu(4'h2);
            rd(lipc_pkg::ADDR_SYSMODE, 8'h01);
         end
         cpu(4'h4);
      end
      complete_run;
   end
endmodule
`default_nettype wire
